/* verilog/link_cfg_pkg.sv */
// Package with register map, field positions and reset values for the link reset and configuration front end.
package link_cfg_pkg;
  localparam logic [7:0] CFG_CMD_OFFSET = 8'h04;
  localparam logic [7:0] CFG_MIXER_BASE_OFFSET = 8'h10;
  localparam logic [7:0] CFG_BM_BASE_OFFSET = 8'h14;
  localparam logic [7:0] CFG_IRQ_LINE_OFFSET = 8'h3c;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [15:0] CMD_WRITE_MASK = 16'h0005;
  localparam int CMD_IO_EN_BIT = 0;
  localparam int CMD_BM_EN_BIT = 2;
  localparam logic [31:0] BASE_RESET = 32'h00000001;
  localparam logic [31:0] BASE_WRITE_MASK = 32'h0000ff00;
  localparam logic [7:0] IRQ_LINE_RESET = 8'h00;
  localparam logic [2:0] FUNC_AUDIO = 3'h5;
  localparam logic [2:0] FUNC_MODEM = 3'h6;
  localparam logic [7:0] GLOB_CTRL_OFFSET = 8'h60;
  localparam logic [7:0] GLOB_STAT_OFFSET = 8'h30;
  localparam logic [7:0] CTRL_COLD_BIT = 8'h01;
  localparam int CODEC_COUNT = 2;
  localparam logic [31:0] DATA_ZERO = 32'h00000000;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] func;
    logic [7:0] offset;
    logic [31:0] wdata;
  } cfg_req_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } io_req_s;
endpackage

/* verilog/cfg_function.sv */
// One PCI configuration function: command word, two I/O base addresses and the interrupt line hint.
`timescale 1ns/100ps
module cfg_function
  import link_cfg_pkg::*;
#(
  parameter logic [2:0] FUNC_NUM = FUNC_AUDIO
) (
  input wire logic clock_in, // System clock.
  input wire logic reset_n_in, // Synchronous reset, active low.
  input wire cfg_req_s req_in, // Configuration request.
  input wire logic [15:0] io_addr_in, // I/O address for window decode.
  output logic hit_out, // Request addresses this function.
  output logic [31:0] rdata_out, // Combinational read data.
  output logic io_en_out, // I/O decoding enabled.
  output logic bm_en_out, // Bus mastering enabled.
  output logic mixer_hit_out, // I/O address inside mixer window.
  output logic bm_hit_out // I/O address inside bus-master window.
);
  logic [15:0] cmd_reg;
  logic [31:0] mixer_base_reg;
  logic [31:0] bm_base_reg;
  logic [7:0] irq_line_reg;

  assign hit_out = req_in.func == FUNC_NUM;

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      cmd_reg <= CMD_RESET;
      mixer_base_reg <= BASE_RESET;
      bm_base_reg <= BASE_RESET;
      irq_line_reg <= IRQ_LINE_RESET;
    end else if (req_in.wr && hit_out) begin
      unique case (req_in.offset)
        CFG_CMD_OFFSET: cmd_reg <= req_in.wdata[15:0] & CMD_WRITE_MASK;
        CFG_MIXER_BASE_OFFSET: mixer_base_reg <= (req_in.wdata & BASE_WRITE_MASK) | BASE_RESET;
        CFG_BM_BASE_OFFSET: bm_base_reg <= (req_in.wdata & BASE_WRITE_MASK) | BASE_RESET;
        CFG_IRQ_LINE_OFFSET: irq_line_reg <= req_in.wdata[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (req_in.offset)
      CFG_CMD_OFFSET: rdata_out = {16'h0000, cmd_reg};
      CFG_MIXER_BASE_OFFSET: rdata_out = mixer_base_reg;
      CFG_BM_BASE_OFFSET: rdata_out = bm_base_reg;
      CFG_IRQ_LINE_OFFSET: rdata_out = {24'h000000, irq_line_reg};
      default: rdata_out = DATA_ZERO;
    endcase
  end

  assign io_en_out = cmd_reg[CMD_IO_EN_BIT];
  assign bm_en_out = cmd_reg[CMD_BM_EN_BIT];
  // Each window is 256 bytes, so only the upper address byte is compared.
  assign mixer_hit_out = io_en_out && (io_addr_in[15:8] == mixer_base_reg[15:8]);
  assign bm_hit_out = io_en_out && (io_addr_in[15:8] == bm_base_reg[15:8]);
endmodule

/* verilog/link_reset_cfg.sv */
// Top of the link reset control and PCI configuration front end.
`timescale 1ns/100ps
// Behaviour
// - At power-up the link reset is driven from the bus reset so controller and codecs start reset.
// - While resuming from sleep the link reset no longer follows the bus reset.
// - Writing zero to the cold-reset bit in the global control register asserts link cold reset.
// - The cold-reset bit keeps its value through sleep so software can pick warm or cold resume.
// - Codec ready is reported only when an attached codec signals readiness.
// - At most two codecs are supported on the link.
// - Audio is function 5 and modem function 6, each with its own configuration registers.
// - The command word resets to zero, bit 2 enables bus mastering and bit 0 enables I/O decoding.
// - Each base address resets to 1, marks I/O space and claims a 256-byte block in 64 KB I/O space.
// - The interrupt line byte resets to zero and is only a hint with no effect on interrupts.
// - Audio and modem interrupts share one interrupt request line.
module link_reset_cfg
  import link_cfg_pkg::*;
(
  input wire logic clock_in, // 25 MHz clock, kept in the suspend well.
  input wire logic reset_n_in, // Suspend-well reset, active low.
  input wire logic bus_reset_n_in, // PCI bus reset pin, active low.
  input wire logic resume_in, // Resume-from-sleep condition level.
  input wire logic [CODEC_COUNT-1:0] codec_ready_in, // Codec ready pins.
  input wire cfg_req_s cfg_req_in, // Configuration request.
  input wire io_req_s io_req_in, // I/O request.
  input wire logic [1:0] func_irq_in, // Audio and modem interrupt requests.
  input wire logic [1:0] xfer_req_in, // DMA start requests per function.
  output logic [31:0] cfg_rdata_out, // Configuration read data.
  output logic [31:0] io_rdata_out, // I/O read data.
  output logic io_claim_out, // I/O access claimed.
  output logic mixer_sel_out, // Access forwarded to the codec mixer.
  output logic link_reset_n_out, // Link reset to the codecs, active low.
  output logic shared_irq_pin_out, // Shared interrupt request, active high.
  output logic [1:0] xfer_go_out // DMA start grants per function.
);
  logic [CODEC_COUNT-1:0] ready_meta_reg;
  logic [CODEC_COUNT-1:0] ready_sync_reg;
  logic bus_rst_meta_reg;
  logic bus_rst_sync_reg;
  logic resume_meta_reg;
  logic resume_sync_reg;
  logic cold_n_reg;
  logic [1:0] hit;
  logic [1:0] io_en;
  logic [1:0] bm_en;
  logic [1:0] mix_hit;
  logic [1:0] bm_hit;
  logic [31:0] rdata [2];
  cfg_req_s fn_req;

  assign fn_req = cfg_req_in;

  cfg_function #(.FUNC_NUM(FUNC_AUDIO)) audio_fn (
    .clock_in(clock_in), .reset_n_in(reset_n_in && bus_rst_sync_reg), .req_in(fn_req),
    .io_addr_in(io_req_in.addr), .hit_out(hit[0]), .rdata_out(rdata[0]), .io_en_out(io_en[0]),
    .bm_en_out(bm_en[0]), .mixer_hit_out(mix_hit[0]), .bm_hit_out(bm_hit[0]));
  cfg_function #(.FUNC_NUM(FUNC_MODEM)) modem_fn (
    .clock_in(clock_in), .reset_n_in(reset_n_in && bus_rst_sync_reg), .req_in(fn_req),
    .io_addr_in(io_req_in.addr), .hit_out(hit[1]), .rdata_out(rdata[1]), .io_en_out(io_en[1]),
    .bm_en_out(bm_en[1]), .mixer_hit_out(mix_hit[1]), .bm_hit_out(bm_hit[1]));

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Only the second stage is read, so a metastable first stage never reaches the logic.
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      ready_meta_reg <= '0;
      ready_sync_reg <= '0;
      bus_rst_meta_reg <= 1'b0;
      bus_rst_sync_reg <= 1'b0;
      resume_meta_reg <= 1'b0;
      resume_sync_reg <= 1'b0;
    end else begin
      ready_meta_reg <= codec_ready_in;
      ready_sync_reg <= ready_meta_reg;
      bus_rst_meta_reg <= bus_reset_n_in;
      bus_rst_sync_reg <= bus_rst_meta_reg;
      resume_meta_reg <= resume_in;
      resume_sync_reg <= resume_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Cold reset control
  // ----------------------------------------------------------------
  // Held only by the suspend-well reset, so a bus reset during sleep leaves it alone.
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      cold_n_reg <= 1'b0;
    end else if (io_req_in.wr && bm_hit[0] && io_req_in.addr[7:0] == GLOB_CTRL_OFFSET) begin
      cold_n_reg <= io_req_in.wdata[0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      link_reset_n_out <= 1'b0;
    end else if (resume_sync_reg) begin
      link_reset_n_out <= cold_n_reg;
    end else begin
      link_reset_n_out <= cold_n_reg && bus_rst_sync_reg;
    end
  end

  // ----------------------------------------------------------------
  // Read paths and claims
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      cfg_rdata_out <= DATA_ZERO;
      io_rdata_out <= DATA_ZERO;
      io_claim_out <= 1'b0;
      mixer_sel_out <= 1'b0;
    end else begin
      cfg_rdata_out <= hit[0] ? rdata[0] : (hit[1] ? rdata[1] : DATA_ZERO);
      io_claim_out <= (io_req_in.rd || io_req_in.wr) && ((|mix_hit) || (|bm_hit));
      mixer_sel_out <= (io_req_in.rd || io_req_in.wr) && (|mix_hit);
      if (io_req_in.rd && bm_hit[0] && io_req_in.addr[7:0] == GLOB_CTRL_OFFSET) begin
        io_rdata_out <= {31'h00000000, cold_n_reg};
      end else if (io_req_in.rd && (|bm_hit) && io_req_in.addr[7:0] == GLOB_STAT_OFFSET) begin
        io_rdata_out <= {30'h00000000, ready_sync_reg};
      end else begin
        io_rdata_out <= DATA_ZERO;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      shared_irq_pin_out <= 1'b0;
      xfer_go_out <= 2'h0;
    end else begin
      // The interrupt line hint is deliberately not read: it only informs software.
      shared_irq_pin_out <= |func_irq_in;
      xfer_go_out <= xfer_req_in & bm_en;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_ready_follows_pin;
    @(posedge clock_in) disable iff (!reset_n_in)
      ($past(reset_n_in) && $past(reset_n_in, 2)) |-> (ready_sync_reg == $past(codec_ready_in, 2));
  endproperty
  a_ready_follows_pin: assert property (p_ready_follows_pin) else $error("codec ready not from pin");

  property p_no_go_without_bm;
    @(posedge clock_in) disable iff (!reset_n_in)
      (xfer_req_in != 2'h0) |=> ((xfer_go_out & ~$past(bm_en)) == 2'h0);
  endproperty
  a_no_go_without_bm: assert property (p_no_go_without_bm) else $error("transfer without bus master");

  property p_cold_holds_link;
    @(posedge clock_in) disable iff (!reset_n_in)
      !cold_n_reg |=> !link_reset_n_out;
  endproperty
  a_cold_holds_link: assert property (p_cold_holds_link) else $error("link out of reset in cold");

  property p_bus_reset_link;
    @(posedge clock_in) disable iff (!reset_n_in)
      (!bus_rst_sync_reg && !resume_sync_reg) |=> !link_reset_n_out;
  endproperty
  a_bus_reset_link: assert property (p_bus_reset_link) else $error("bus reset not on link");

  property p_resume_ignores_bus;
    @(posedge clock_in) disable iff (!reset_n_in)
      (resume_sync_reg && cold_n_reg) |=> link_reset_n_out;
  endproperty
  a_resume_ignores_bus: assert property (p_resume_ignores_bus) else $error("link followed bus in resume");

  property p_cold_kept;
    @(posedge clock_in) disable iff (!reset_n_in)
      !(io_req_in.wr && bm_hit[0]) |=> $stable(cold_n_reg);
  endproperty
  a_cold_kept: assert property (p_cold_kept) else $error("cold bit changed without write");

  property p_irq_shared;
    @(posedge clock_in) disable iff (!reset_n_in)
      (func_irq_in != 2'h0) |=> shared_irq_pin_out;
  endproperty
  a_irq_shared: assert property (p_irq_shared) else $error("shared irq missing");

  property p_no_claim_disabled;
    @(posedge clock_in) disable iff (!reset_n_in)
      (io_en == 2'h0) |=> !io_claim_out;
  endproperty
  a_no_claim_disabled: assert property (p_no_claim_disabled) else $error("claim with io disabled");

  property p_no_mixer_disabled;
    @(posedge clock_in) disable iff (!reset_n_in)
      (io_en == 2'h0) |=> !mixer_sel_out;
  endproperty
  a_no_mixer_disabled: assert property (p_no_mixer_disabled) else $error("mixer select with io disabled");

  property p_irq_quiet;
    @(posedge clock_in) disable iff (!reset_n_in)
      (func_irq_in == 2'h0) |=> !shared_irq_pin_out;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("shared irq without request");

  property p_cfg_miss_zero;
    @(posedge clock_in) disable iff (!reset_n_in)
      (cfg_req_in.func != FUNC_AUDIO && cfg_req_in.func != FUNC_MODEM) |=> (cfg_rdata_out == DATA_ZERO);
  endproperty
  a_cfg_miss_zero: assert property (p_cfg_miss_zero) else $error("data from absent function");

  property p_io_idle_zero;
    @(posedge clock_in) disable iff (!reset_n_in)
      !io_req_in.rd |=> (io_rdata_out == DATA_ZERO);
  endproperty
  a_io_idle_zero: assert property (p_io_idle_zero) else $error("io data without read");

  property p_stat_no_ready;
    @(posedge clock_in) disable iff (!reset_n_in)
      (io_req_in.rd && (|bm_hit) && io_req_in.addr[7:0] == GLOB_STAT_OFFSET && ready_sync_reg == 2'h0)
        |=> (io_rdata_out == DATA_ZERO);
  endproperty
  a_stat_no_ready: assert property (p_stat_no_ready) else $error("ready reported without codec");
endmodule

/* tb/codec_model.sv */
// Behavioural model of up to two link codecs that report ready after link reset.
`timescale 1ns/100ps
module codec_model #(
  parameter int READY_DELAY = 4
) (
  input wire logic clock_in, // System clock.
  input wire logic link_reset_n_in, // Link reset, active low.
  input wire logic [1:0] present_in, // Codecs attached, bit 0 primary.
  output logic [1:0] ready_out // Codec ready pins.
);
  int cnt;
  // An absent codec, or one held in reset, never reports ready.
  always @(posedge clock_in) begin
    if (!link_reset_n_in) cnt <= 0;
    else if (cnt < READY_DELAY) cnt <= cnt + 1;
  end
  assign ready_out = (link_reset_n_in && cnt == READY_DELAY) ? present_in : 2'h0;
endmodule

/* tb/link_reset_cfg_bench.sv */
// Self-checking bench for the link reset and configuration front end.
`timescale 1ns/100ps
module link_reset_cfg_bench import link_cfg_pkg::*; ();
  logic clock_in, reset_n_in, bus_reset_n_in, resume_in, io_claim, mixer_sel, link_reset_n, shared_irq;
  logic [1:0] ready, func_irq, xfer_req, xfer_go, present;
  cfg_req_s cfg_req;
  io_req_s io_req;
  logic [31:0] cfg_rdata, io_rdata, r;
  int err_total, checked, cycles;

  link_reset_cfg dut_u (.clock_in(clock_in), .reset_n_in(reset_n_in), .bus_reset_n_in(bus_reset_n_in),
    .resume_in(resume_in), .codec_ready_in(ready), .cfg_req_in(cfg_req), .io_req_in(io_req),
    .func_irq_in(func_irq), .xfer_req_in(xfer_req), .cfg_rdata_out(cfg_rdata), .io_rdata_out(io_rdata),
    .io_claim_out(io_claim), .mixer_sel_out(mixer_sel), .link_reset_n_out(link_reset_n),
    .shared_irq_pin_out(shared_irq), .xfer_go_out(xfer_go));
  codec_model codec_u (.clock_in(clock_in), .link_reset_n_in(link_reset_n), .present_in(present),
    .ready_out(ready));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  // Requests are single-cycle pulses; outputs are sampled just after the edge that takes them.
  task automatic cfg(input logic w, input logic [2:0] f, input logic [7:0] o, input logic [31:0] d);
    @(posedge clock_in);
    cfg_req <= '{~w, w, f, o, d};
    @(posedge clock_in);
    cfg_req <= '0;
    #1;
  endtask
  task automatic io(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clock_in);
    io_req <= '{~w, w, a, d};
    @(posedge clock_in);
    io_req <= '0;
    #1;
  endtask
  // Function f gets its mixer window at f000h and bus-master window at f100h.
  task automatic setup();
    for (int f = 5; f <= 6; f++) begin
      cfg(1, 3'(f), CFG_MIXER_BASE_OFFSET, 32'(f) << 12);
      cfg(1, 3'(f), CFG_BM_BASE_OFFSET, (32'(f) << 12) | 32'h100);
      cfg(1, 3'(f), CFG_CMD_OFFSET, 32'h5);
    end
  endtask

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    clock_in = 0;
    forever #20 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    {reset_n_in, bus_reset_n_in, resume_in, func_irq, xfer_req, cycles, err_total, checked} = '0;
    cfg_req = '0;
    io_req = '0;
    present = 2'h1;
    r = $urandom(35);
    repeat (2) @(posedge clock_in);
    reset_n_in <= 1;
    wait_n(4);
    chk(32'(link_reset_n), 0);
    @(posedge clock_in);
    bus_reset_n_in <= 1;
    wait_n(4);
    for (int f = 4; f <= 6; f++) begin
      cfg(0, 3'(f), CFG_CMD_OFFSET, 0);
      chk(cfg_rdata, 0);
      cfg(0, 3'(f), CFG_MIXER_BASE_OFFSET, 0);
      chk(cfg_rdata, f == 4 ? 0 : 32'h1);
      cfg(0, 3'(f), CFG_BM_BASE_OFFSET, 0);
      chk(cfg_rdata, f == 4 ? 0 : 32'h1);
      cfg(0, 3'(f), CFG_IRQ_LINE_OFFSET, 0);
      chk(cfg_rdata, 0);
    end
    io(0, 16'h0002, 0);
    chk(32'(io_claim), 0);
    r = $urandom();
    cfg(1, FUNC_MODEM, CFG_CMD_OFFSET, r);
    cfg(0, FUNC_MODEM, CFG_CMD_OFFSET, 0);
    chk(cfg_rdata, r & 32'h5);
    cfg(0, FUNC_AUDIO, CFG_CMD_OFFSET, 0);
    chk(cfg_rdata, 0);
    r = $urandom();
    cfg(1, FUNC_MODEM, CFG_MIXER_BASE_OFFSET, r);
    cfg(0, FUNC_MODEM, CFG_MIXER_BASE_OFFSET, 0);
    chk(cfg_rdata, (r & 32'hff00) | 32'h1);
    r = $urandom();
    cfg(1, FUNC_MODEM, CFG_IRQ_LINE_OFFSET, r);
    cfg(0, FUNC_MODEM, CFG_IRQ_LINE_OFFSET, 0);
    chk(cfg_rdata, r & 32'hff);
    setup();
    io(0, 16'h5130, 0);
    chk(io_rdata, 0);
    io(1, 16'h5160, 32'h1);
    wait_n(3);
    chk(32'(link_reset_n), 32'h1);
    wait_n(10);
    // Codec ready is confirmed before the first access to any mixer window.
    io(0, 16'h5130, 0);
    chk(io_rdata, 32'(present));
    for (int f = 5; f <= 6; f++) begin
      io(0, 16'(f << 12), 0);
      chk({30'h0, io_claim, mixer_sel}, 32'h3);
      io(0, 16'(f << 12) | 16'h80, 0);
      chk({30'h0, io_claim, mixer_sel}, 32'h3);
      io(0, 16'(f << 12) | 16'h1ff, 0);
      chk({30'h0, io_claim, mixer_sel}, 32'h2);
    end
    io(0, 16'h7000, 0);
    chk(32'(io_claim), 0);
    repeat (8) begin
      r = $urandom();
      @(posedge clock_in);
      xfer_req <= r[1:0];
      func_irq <= r[3:2];
      wait_n(4);
      chk(32'(xfer_go), 32'(r[1:0]));
      chk(32'(shared_irq), 32'(|r[3:2]));
    end
    cfg(1, FUNC_MODEM, CFG_CMD_OFFSET, 32'h1);
    @(posedge clock_in);
    xfer_req <= 2'h3;
    wait_n(2);
    chk(32'(xfer_go), 32'h1);
    // The bus reset during resume clears configuration but must leave the link alone.
    @(posedge clock_in);
    resume_in <= 1;
    wait_n(4);
    @(posedge clock_in);
    bus_reset_n_in <= 0;
    wait_n(6);
    chk(32'(link_reset_n), 32'h1);
    @(posedge clock_in);
    bus_reset_n_in <= 1;
    wait_n(4);
    @(posedge clock_in);
    resume_in <= 0;
    wait_n(4);
    setup();
    io(0, 16'h5160, 0);
    chk(io_rdata, 32'h1);
    io(1, 16'h5160, 0);
    wait_n(3);
    chk(32'(link_reset_n), 0);
    wait_n(6);
    io(0, 16'h5130, 0);
    chk(io_rdata, 0);
    print_verdict();
  end
endmodule
